// ---- design/port_pin_function_select.sv ----
// Port lines, direction, input gating and pin-function routing
`timescale 1ns/1ns
`default_nettype none
module port_pin_function_select #(
  parameter int ADDR_W = 12  // Word address width
) (
  input wire logic clk_in,                   // System clock, 100 MHz
  input wire logic reset_in,                 // Async reset, active high
  input wire logic wb_cyc_i,                 // Wishbone cycle
  input wire logic wb_stb_i,                 // Wishbone strobe
  input wire logic wb_we_i,                  // Wishbone write enable
  input wire logic [ADDR_W+1:2] wb_adr_i,    // Wishbone word address
  input wire logic [3:0] wb_sel_i,           // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,          // Wishbone write data
  output logic [31:0] wb_dat_o,              // Wishbone read data
  output logic wb_ack_o,                     // Wishbone acknowledge
  input wire logic mode_strap_a_in,          // First mode strap
  input wire logic mode_strap_b_in,          // Second mode strap
  input wire logic flash_program_pin_in,     // Flash program pin
  input wire logic [183:0] pin_in,           // Pad input levels
  output logic [183:0] pin_out,              // Pad output levels
  output logic [183:0] pin_oe_n_out,         // Pad drive enable, low drives
  input wire logic [183:0] periph_out_in,    // Peripheral output levels
  input wire logic [183:0] periph_oe_in,     // Peripheral drive request
  input wire logic [183:0] ext_out_in,       // External bus output levels
  input wire logic [183:0] ext_oe_in,        // External bus drive request
  output logic [183:0] line_in_out,          // Gated pad levels to users
  output var port_pkg::cpu_mode_type cpu_mode_out  // Held CPU operation mode
);
  import port_pkg::*;

  // The register decode slices a 12-bit index, so no other width is served
  if (ADDR_W != 12) begin : g_addr_w_check
    $error("ADDR_W must be 12");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Index hit on one of the 23 group slots of a register bank
  // Indices past the last slot, or slots of absent groups, miss
  function automatic logic bank_hit(input logic [11:0] a, input logic [11:0] base,
                                    input logic [22:0] present);
    logic [11:0] off;
    off = a - base;
    return (off < 12'd23) && present[off[4:0]];
  endfunction

  // Slot number of an index inside a bank
  function automatic logic [4:0] bank_slot(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    return off[4:0];
  endfunction

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // Straps are taken once after reset; the flash pin goes in only so that
  // the capture module can show it never moves the mode
  cpu_mode_type cpu_mode;  // Held operation mode

  strap_mode_latch u_strap (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .mode_strap_a_in(mode_strap_a_in),
    .mode_strap_b_in(mode_strap_b_in),
    .flash_program_pin_in(flash_program_pin_in),
    .cpu_mode_out(cpu_mode)
  );

  // Both extension and processor mode hand the low groups to the bus
  logic ext_mode;  // External extension or processor mode
  assign ext_mode = (cpu_mode != MODE_SINGLE);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Each bank keeps all 23 group slots so a slot number indexes it directly;
  // slots of absent groups are masked to zero and hold no real state
  logic [183:0] data_q, data_d;  // Output latches
  logic [183:0] dir_q, dir_d;    // Direction, 1 is output
  logic [183:0] mode_q, mode_d;  // Function select, 1 is peripheral
  logic ie_q, ie_d;              // Global input enable
  logic ack_q, ack_d;            // Bus acknowledge
  logic [31:0] rdat_q, rdat_d;   // Read data
  logic [183:0] gated_in;        // Pads after the input gate
  logic req;                     // New bus request
  logic [11:0] idx;              // Register index

  // Input buffers pass nothing while the enable is clear
  assign gated_in = pin_in & LINE_EXISTS & {184{ie_q}};
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign idx = wb_adr_i[13:2];

  // Next register values and bus answer
  always_comb begin
    logic [4:0] s;
    logic [7:0] rb;
    s = 5'd0;
    rb = 8'h00;
    data_d = data_q;
    dir_d = dir_q;
    mode_d = mode_q;
    ie_d = ie_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    if (req) begin
      ack_d = 1'b1;
      if (bank_hit(idx, DATA_BASE_IDX, PORT_GROUPS)) begin
        s = bank_slot(idx, DATA_BASE_IDX);
        // Output lines show the latch, input lines the gated pad
        rb = ((dir_q[s*8 +: 8] & data_q[s*8 +: 8])
             | (~dir_q[s*8 +: 8] & gated_in[s*8 +: 8]))
             & LINE_EXISTS[s*8 +: 8];
        // Group 8 low bits mirror the straps
        if (s == 5'd8) begin
          rb[0] = mode_strap_a_in;
          rb[1] = mode_strap_b_in;
        end
        if (wb_we_i && wb_sel_i[0]) begin
          // Input-only and absent lines keep no latch bit
          data_d[s*8 +: 8] = wb_dat_i[7:0] & WRITABLE[s*8 +: 8];
        end
      end else if (bank_hit(idx, DIR_BASE_IDX, PORT_GROUPS)) begin
        s = bank_slot(idx, DIR_BASE_IDX);
        rb = dir_q[s*8 +: 8];
        if (wb_we_i && wb_sel_i[0]) begin
          // Every writable line gets its own direction bit
          dir_d[s*8 +: 8] = wb_dat_i[7:0] & WRITABLE[s*8 +: 8];
        end
      end else if (bank_hit(idx, MODE_BASE_IDX, MODE_GROUPS)) begin
        s = bank_slot(idx, MODE_BASE_IDX);
        rb = mode_q[s*8 +: 8];
        if (wb_we_i && wb_sel_i[0]) begin
          // Only peripheral-capable lines of groups 7 upward
          mode_d[s*8 +: 8] = wb_dat_i[7:0] & PERIPH_CAPABLE[s*8 +: 8];
        end
      end else if (idx == INEN_IDX) begin
        rb[GLOBAL_IE_POS] = ie_q;
        if (wb_we_i && wb_sel_i[0]) begin
          ie_d = wb_dat_i[GLOBAL_IE_POS];
        end
      end
      // Unmapped indices answer with zero and drop writes
      rdat_d = {24'h0, rb};
    end
  end

  // Registers only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      data_q <= DATA_RESET;
      dir_q <= DIR_RESET;
      mode_q <= MODE_RESET;
      ie_q <= INEN_RESET;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      data_q <= data_d;
      dir_q <= dir_d;
      mode_q <= mode_d;
      ie_q <= ie_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------
  logic [183:0] pout_d, poen_d;  // Next pad drive
  logic [183:0] pout_q, poen_q;  // Registered pad drive
  logic [183:0] lin_q;           // Registered gated input

  // The select bank is masked to peripheral-capable lines, so a stray select
  // bit can never take a line that the external bus owns in extension modes
  // Pick the owner of each pad: external bus, peripheral or port
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      if (!LINE_EXISTS[i]) begin
        pout_d[i] = 1'b0;
        poen_d[i] = 1'b1;
      end else if (ext_mode && EXT_LINES[i]) begin
        pout_d[i] = ext_out_in[i];
        poen_d[i] = !ext_oe_in[i];
      end else if (mode_q[i]) begin
        // The peripheral muxes its own alternatives before this point
        pout_d[i] = periph_out_in[i];
        poen_d[i] = !periph_oe_in[i];
      end else begin
        pout_d[i] = data_q[i];
        poen_d[i] = !dir_q[i];
      end
    end
  end

  // Registers only; one cycle of latency keeps outputs glitch free
  // Reset leaves every pad undriven so board levels and straps win
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pout_q <= 184'h0;
      poen_q <= {184{1'b1}};
      lin_q <= 184'h0;
    end else begin
      pout_q <= pout_d;
      poen_q <= poen_d;
      lin_q <= gated_in;
    end
  end

  // Every top-level output comes straight from a flop
  assign pin_out = pout_q;
  assign pin_oe_n_out = poen_q;
  assign line_in_out = lin_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign cpu_mode_out = cpu_mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks run on the one system clock and sleep through reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence rd_data0;
    req && !wb_we_i && idx == DATA_BASE_IDX;
  endsequence
  sequence wr_dir0;
    req && wb_we_i && wb_sel_i[0] && idx == DIR_BASE_IDX;
  endsequence
  sequence wr_inen;
    req && wb_we_i && wb_sel_i[0] && idx == INEN_IDX;
  endsequence
  // A write with byte lane 0 off must leave the register alone
  sequence wr_dir0_nosel;
    req && wb_we_i && !wb_sel_i[0] && idx == DIR_BASE_IDX;
  endsequence
  // Group 8 data read shows the strap pins live
  sequence rd_strap;
    req && !wb_we_i && idx == DATA_BASE_IDX + 12'h008;
  endsequence

  chk_dir_write: assert property (wr_dir0 |=> dir_q[7:0] == $past(wb_dat_i[7:0]))
    else $error("direction write lost");
  chk_input_only: assert property (!dir_q[SERIAL_IN_POS] && !dir_q[CAN_RX_POS]
    && poen_q[SERIAL_IN_POS] && poen_q[CAN_RX_POS])
    else $error("input-only line drives");
  chk_ext_handover: assert property (ext_mode |=> pout_q[0] == $past(ext_out_in[0])
    && poen_q[0] == !$past(ext_oe_in[0]))
    else $error("external bus not on group 0");
  chk_port_drive: assert property (!ext_mode && dir_q[0] |=> !poen_q[0]
    && pout_q[0] == $past(data_q[0]))
    else $error("port latch not on pad");
  chk_periph_route: assert property (mode_q[56] |=> pout_q[56] == $past(periph_out_in[56]))
    else $error("peripheral not routed");
  chk_mode_mask: assert property ((mode_q & ~PERIPH_CAPABLE) == 184'h0)
    else $error("select bit outside capable lines");
  chk_absent_lines: assert property (((data_q | dir_q) & ~LINE_EXISTS) == 184'h0
    && poen_q[47:40] == 8'hff)
    else $error("absent line holds state");
  chk_input_gate: assert property (!ie_q |=> lin_q == 184'h0)
    else $error("input passed while disabled");
  // Input enable: only a bus write may open the input gate
  chk_ie_holds: assert property (!ie_q
    && !(req && wb_we_i && wb_sel_i[0] && idx == INEN_IDX) |=> !ie_q)
    else $error("input enable set by itself");
  chk_ie_write: assert property (wr_inen |=> ie_q == $past(wb_dat_i[GLOBAL_IE_POS]))
    else $error("input enable write lost");
  chk_gate_pass: assert property (ie_q |=> lin_q[7:0] == $past(pin_in[7:0]))
    else $error("enabled input not passed");
  chk_sel_refused: assert property (wr_dir0_nosel |=> $stable(dir_q[7:0]))
    else $error("write without lane 0 landed");
  // The extra line follows the same handover as groups 0-4
  chk_extra_line: assert property (ext_mode
    |=> pout_q[EXTRA_POS] == $past(ext_out_in[EXTRA_POS])
    && poen_q[EXTRA_POS] == !$past(ext_oe_in[EXTRA_POS]))
    else $error("extra line not handed over");
  chk_read_mux: assert property (rd_data0 |=> wb_ack_o && wb_dat_o[0] ==
    ($past(dir_q[0]) ? $past(data_q[0]) : $past(gated_in[0])))
    else $error("data read mux wrong");
  // Strap mirror is live, not the captured mode, so board faults show up
  chk_strap_read: assert property (rd_strap |=> wb_dat_o[1] == $past(mode_strap_b_in)
    && wb_dat_o[0] == $past(mode_strap_a_in))
    else $error("strap levels not read");

endmodule // port_pin_function_select
`default_nettype wire

// ---- design/port_pkg.sv ----
// Shared constants and types for the port and pin-function block
package port_pkg;

  // ----------------------------------------------------------------
  // Line layout: 23 group slots of 8 lines, line i is group i/8 bit i%8
  // ----------------------------------------------------------------
  localparam int GROUPS = 23;
  localparam int LINES = GROUPS * 8;
  localparam int PORT_LINES = 97;

  // Lines that physically exist, group 22 down to group 0
  localparam logic [183:0] LINE_EXISTS = {
    8'h23, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h09,
    8'h00, 8'hff, 8'hf0, 8'hff, 8'hff, 8'hf8, 8'hfc, 8'hff,
    8'h1e, 8'h00, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff};

  // Special line positions
  localparam int SERIAL_IN_POS = 52;   // Serial bus input line, input only
  localparam int CAN_RX_POS = 177;     // CAN receive line, input only
  localparam int EXTRA_POS = 181;      // Mode-controlled extra line
  localparam int STRAP_A_POS = 64;     // Group 8 bit 0 reads mode_strap_a
  localparam int STRAP_B_POS = 65;     // Group 8 bit 1 reads mode_strap_b

  // Groups that carry data and direction registers
  localparam logic [22:0] PORT_GROUPS = 23'h42bfdf;
  // Groups that carry a port_function_select_register
  localparam logic [22:0] MODE_GROUPS = 23'h42bf80;

  localparam logic [183:0] ONE_LINE = 184'h1;
  localparam logic [183:0] WRITABLE =
    LINE_EXISTS & ~(ONE_LINE << SERIAL_IN_POS) & ~(ONE_LINE << CAN_RX_POS);
  localparam logic [183:0] PERIPH_CAPABLE =
    LINE_EXISTS & {{128{1'b1}}, 56'h0} & ~(ONE_LINE << CAN_RX_POS)
    & ~(ONE_LINE << EXTRA_POS);
  localparam logic [183:0] EXT_LINES =
    (LINE_EXISTS & {144'h0, 40'hff_ffff_ffff}) | (ONE_LINE << EXTRA_POS);

  // ----------------------------------------------------------------
  // Register indices; byte address on the bus is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] DATA_BASE_IDX = 12'h700;
  localparam logic [11:0] DIR_BASE_IDX = 12'h720;
  localparam logic [11:0] MODE_BASE_IDX = 12'h740;
  localparam logic [11:0] INEN_IDX = 12'h745;
  localparam int GLOBAL_IE_POS = 0;

  // Reset values
  localparam logic [183:0] DATA_RESET = 184'h0;
  localparam logic [183:0] DIR_RESET = 184'h0;
  localparam logic [183:0] MODE_RESET = 184'h0;
  localparam logic INEN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b001,
    MODE_EXT = 3'b010,
    MODE_PROC = 3'b100
  } cpu_mode_type;

  typedef enum logic [1:0] {
    LATCH_WAIT = 2'b01,
    LATCH_HELD = 2'b10
  } latch_state_type;

endpackage

// ---- design/strap_mode_latch.sv ----
// Captures the mode straps once after reset and holds the CPU mode
`timescale 1ns/1ns
`default_nettype none
module strap_mode_latch (
  input wire logic clk_in,                      // System clock
  input wire logic reset_in,                    // Async reset, active high
  input wire logic mode_strap_a_in,             // First mode strap
  input wire logic mode_strap_b_in,             // Second mode strap
  input wire logic flash_program_pin_in,        // Flash program pin, no effect
  output var port_pkg::cpu_mode_type cpu_mode_out   // Held CPU operation mode
);
  import port_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  latch_state_type state_q, state_d;  // Capture sequencer
  cpu_mode_type mode_q, mode_d;       // Decoded mode

  // Next values: straps are taken on the first edge after release only
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    unique case (state_q)
      LATCH_WAIT: begin
        state_d = LATCH_HELD;
        // Reserved high/high is steered to single-chip as the safe choice
        unique case ({mode_strap_a_in, mode_strap_b_in})
          2'b01: mode_d = MODE_EXT;
          2'b10: mode_d = MODE_PROC;
          default: mode_d = MODE_SINGLE;
        endcase
      end
      LATCH_HELD: begin
        // Strap and flash pin activity later cannot move the mode
        state_d = LATCH_HELD;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= LATCH_WAIT;
      mode_q <= MODE_SINGLE;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
    end
  end

  assign cpu_mode_out = mode_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mode_held: assert property (@(posedge clk_in) disable iff (reset_in)
    state_q == LATCH_HELD |=> $stable(mode_q))
    else $error("mode changed after capture");
  chk_flash_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == LATCH_HELD && $changed(flash_program_pin_in)) |=> mode_q == $past(mode_q))
    else $error("flash pin moved the mode");
  chk_strap_decode: assert property (@(posedge clk_in) disable iff (reset_in)
    (state_q == LATCH_WAIT && !mode_strap_a_in && mode_strap_b_in) |=> mode_q == MODE_EXT)
    else $error("low/high strap not external mode");

endmodule // strap_mode_latch
`default_nettype wire

// ---- tb/pad_board_model.sv ----
// Board side of the pads: resolves each pad from the block drive and the board level
`timescale 1ns/1ns
`default_nettype none
module pad_board_model (
  input wire logic [183:0] pin_out_in,      // Block pad levels
  input wire logic [183:0] pin_oe_n_in,     // Block drive enable, low drives
  input wire logic [183:0] board_level_in,  // Level the board applies when undriven
  output logic [183:0] pad_out              // Resolved pad level back to the block
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // A driven pad shows the block level; otherwise the board level, which
  // the bench reshuffles so a stale value never passes for a real one
  assign pad_out = (pin_out_in & ~pin_oe_n_in) | (board_level_in & pin_oe_n_in);
endmodule // pad_board_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the port and pin-function block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import port_pkg::*;
  logic clk_in, reset_in, wb_cyc, wb_stb, wb_we, wb_ack, strap_a, strap_b, flash_pin, en_m;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, seed, rd;
  logic [183:0] pin_in, pin_out, pin_oe_n, periph_out, periph_oe, ext_out, ext_oe;
  logic [183:0] line_in, board, dir_m, dat_m, sel_m;
  cpu_mode_type cpu_mode, mode_m;
  int n_mismatch, comparisons;
  logic [11:0] holes [5];  // Indices that must read zero and drop writes
  logic [1:0] straps [3];  // Strap pairs for the later mode resets
  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  port_pin_function_select dut_u (.clk_in(clk_in), .reset_in(reset_in), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .mode_strap_a_in(strap_a),
    .mode_strap_b_in(strap_b), .flash_program_pin_in(flash_pin), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n), .periph_out_in(periph_out),
    .periph_oe_in(periph_oe), .ext_out_in(ext_out), .ext_oe_in(ext_oe),
    .line_in_out(line_in), .cpu_mode_out(cpu_mode));
  pad_board_model board_u (.pin_out_in(pin_out), .pin_oe_n_in(pin_oe_n),
    .board_level_in(board), .pad_out(pin_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [183:0] rnd184();
    logic [191:0] t;
    t = {xs(), xs(), xs(), xs(), xs(), xs()};
    return t[183:0];
  endfunction
  // Expected drive enable and level per line, by the routing priority
  task automatic exp_pins(output logic [183:0] oen, output logic [183:0] lvl);
    for (int i = 0; i < 184; i++) begin
      if (!LINE_EXISTS[i]) begin
        oen[i] = 1'b1;
        lvl[i] = 1'b0;
      end else if (mode_m != MODE_SINGLE && EXT_LINES[i]) begin
        oen[i] = ~ext_oe[i];
        lvl[i] = ext_out[i];
      end else if (sel_m[i] && PERIPH_CAPABLE[i] && MODE_GROUPS[i / 8]) begin
        oen[i] = ~periph_oe[i];
        lvl[i] = periph_out[i];
      end else begin
        oen[i] = ~(dir_m[i] & WRITABLE[i]);
        lvl[i] = dat_m[i];
      end
    end
  endtask
  // Expected data read: latch when output, gated pad when input
  function automatic logic [7:0] exp_rd(input int g);
    logic [7:0] r;
    int i;
    for (int b = 0; b < 8; b++) begin
      i = g * 8 + b;
      if (i == STRAP_A_POS) r[b] = strap_a;
      else if (i == STRAP_B_POS) r[b] = strap_b;
      else if (!LINE_EXISTS[i]) r[b] = 1'b0;
      else if (dir_m[i] & WRITABLE[i]) r[b] = dat_m[i];
      else r[b] = pin_in[i] & en_m;
    end
    return r;
  endfunction
  task automatic check(input logic [183:0] got, input logic [183:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d,
                    input logic [3:0] sel);
    int n;
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= idx;
    wb_sel <= sel;
    wb_wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Write and mirror the write in the bench's own copy of the registers
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    int g;
    wb(1'b1, idx, d, 4'h1);
    g = int'(idx[4:0]);
    if (idx == INEN_IDX) en_m = d[0];
    else if (idx[11:5] == DATA_BASE_IDX[11:5] && PORT_GROUPS[g]) dat_m[g*8 +: 8] = d;
    else if (idx[11:5] == DIR_BASE_IDX[11:5] && PORT_GROUPS[g]) dir_m[g*8 +: 8] = d;
    else if (idx[11:5] == MODE_BASE_IDX[11:5] && MODE_GROUPS[g]) sel_m[g*8 +: 8] = d;
  endtask
  task automatic pins_chk();
    logic [183:0] oen, lvl;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    exp_pins(oen, lvl);
    check(pin_oe_n, oen);
    check(pin_out & ~oen, lvl & ~oen);
  endtask
  task automatic rst(input logic a, input logic b);
    @(posedge clk_in);
    reset_in <= 1'b1;
    strap_a <= a;
    strap_b <= b;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    {dir_m, dat_m, sel_m, en_m} = '0;
    mode_m = a ? MODE_PROC : (b ? MODE_EXT : MODE_SINGLE);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic results();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    n_mismatch++;
    results();
  end
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat, strap_a, strap_b, flash_pin} = '0;
    {periph_out, periph_oe, ext_out, ext_oe, board, dir_m, dat_m, sel_m, en_m} = '0;
    reset_in = 1'b1;
    seed = 32'd44763;
    n_mismatch = 0;
    comparisons = 0;
    holes = '{12'h705, 12'h725, 12'h746, 12'h74e, 12'h714};
    straps = '{2'b01, 2'b10, 2'b00};
    rst(1'b0, 1'b0);
    board <= rnd184();
    check(pin_oe_n, {184{1'b1}});
    check({181'h0, cpu_mode}, {181'h0, MODE_SINGLE});
    for (int g = 0; g < GROUPS; g++) begin
      if (PORT_GROUPS[g]) begin
        wb(1'b0, DATA_BASE_IDX + 12'(g), 8'h00, 4'h1);
        check({152'h0, rd}, {176'h0, exp_rd(g)});
        wb(1'b0, DIR_BASE_IDX + 12'(g), 8'h00, 4'h1);
        check({152'h0, rd}, 184'h0);
      end
    end
    check(line_in, 184'h0);
    wb(1'b0, INEN_IDX, 8'h00, 4'h1);
    check({152'h0, rd}, 184'h0);
    wr(INEN_IDX, 8'h01);
    repeat (3) @(posedge clk_in);
    check(line_in, pin_in & LINE_EXISTS);
    foreach (holes[k]) begin
      wr(holes[k], 8'hff);
      wb(1'b0, holes[k], 8'h00, 4'h1);
      check({152'h0, rd}, 184'h0);
    end
    for (int r = 0; r < 4; r++) begin
      for (int g = 0; g < GROUPS; g++) begin
        if (PORT_GROUPS[g]) wr(DIR_BASE_IDX + 12'(g), (r == 0) ? 8'hff : 8'(xs()));
        if (PORT_GROUPS[g]) wr(DATA_BASE_IDX + 12'(g), 8'(xs()));
        if (MODE_GROUPS[g]) wr(MODE_BASE_IDX + 12'(g), (r == 1) ? 8'hff : 8'(xs()));
      end
      periph_oe <= rnd184();
      periph_out <= rnd184();
      board <= rnd184();
      pins_chk();
      for (int g = 0; g < GROUPS; g++) begin
        if (PORT_GROUPS[g]) begin
          wb(1'b0, DIR_BASE_IDX + 12'(g), 8'h00, 4'h1);
          check({152'h0, rd}, {176'h0, dir_m[g*8 +: 8] & WRITABLE[g*8 +: 8]});
          wb(1'b0, DATA_BASE_IDX + 12'(g), 8'h00, 4'h1);
          check({152'h0, rd}, {176'h0, exp_rd(g)});
        end
        if (MODE_GROUPS[g]) begin
          wb(1'b0, MODE_BASE_IDX + 12'(g), 8'h00, 4'h1);
          check({152'h0, rd}, {176'h0, sel_m[g*8 +: 8] & PERIPH_CAPABLE[g*8 +: 8]});
        end
      end
    end
    wb(1'b1, DIR_BASE_IDX, ~dir_m[7:0], 4'h0);
    wb(1'b0, DIR_BASE_IDX, 8'h00, 4'h1);
    check({152'h0, rd}, {176'h0, dir_m[7:0]});
    foreach (straps[k]) begin
      rst(straps[k][1], straps[k][0]);
      wr(DIR_BASE_IDX, 8'hff);
      ext_oe <= rnd184();
      ext_out <= rnd184();
      strap_b <= ~strap_b;
      flash_pin <= ~flash_pin;
      pins_chk();
      check({181'h0, cpu_mode}, {181'h0, mode_m});
      wb(1'b0, DATA_BASE_IDX + 12'd8, 8'h00, 4'h1);
      check({182'h0, rd[1:0]}, {182'h0, strap_b, strap_a});
    end
    results();
  end
endmodule // testbench
`default_nettype wire
